// >>> common/uirs_pkg.sv
// uirs_pkg: constants for one uart channel's auxiliary modes and decode.
// assumes 8-bit host data bus with three address lines per channel.
package uirs_pkg;
    // ********************************************************
    // register offsets
    // ********************************************************
    localparam logic [2:0] OFS_DATA = 3'h0;
    localparam logic [2:0] OFS_IEN = 3'h1;
    localparam logic [2:0] OFS_ISTAT = 3'h2;
    localparam logic [2:0] OFS_LCTL = 3'h3;
    localparam logic [2:0] OFS_MCTL = 3'h4;
    localparam logic [2:0] OFS_LSTAT = 3'h5;
    localparam logic [2:0] OFS_MSTAT = 3'h6;
    localparam logic [2:0] OFS_SCRATCH = 3'h7;
    localparam logic [7:0] ENH_KEY = 8'hBF;
    // ********************************************************
    // field positions
    // ********************************************************
    localparam int DIV_ACCESS_POS = 7;
    localparam int IR_ENABLE_POS = 6;
    localparam int LOOPBACK_POS = 4;
    localparam int SLEEP_EN_POS = 4;
    localparam int RX_INVERT_POS = 2;
    localparam int LEVEL_SEL_POS = 6;
    localparam int NO_INT_POS = 0;
    localparam int LSR_DR_POS = 0;
    localparam int LSR_THRE_POS = 5;
    localparam int LSR_TEMT_POS = 6;
    // ********************************************************
    // reset values and timing
    // ********************************************************
    localparam logic [7:0] ZERO_RESET = 8'h00;
    localparam logic [7:0] ISTAT_IDLE = 8'h01;
    localparam logic [7:0] LCTL_RESET = 8'h03;
    localparam int OVERSAMPLE = 16;
    localparam int IR_PULSE_SIXTEENTHS = 3;
    localparam int WAKE_SETTLE_US = 100;
    localparam int CLK_MHZ = 10;
    localparam int WAKE_SETTLE_CYC = WAKE_SETTLE_US * CLK_MHZ;
    localparam int FIFO_DEPTH = 32;
endpackage

// >>> logic/uirs_fifo.sv
// uirs_fifo: width/depth parameterised fifo with valid/ready both sides.
// assumes single clock, depth a power of two.
`timescale 1ns/1ns
`default_nettype none
module uirs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData,
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic doWrite;
    logic doRead;
    assign inReady = (level != (AW+1)'(DEPTH));
    assign outValid = (level != '0);
    assign outData = mem[rdPtr];
    assign doWrite = inValid && inReady;
    assign doRead = outValid && outReady;
    // storage has no reset, pointers do
    always_ff @(posedge ref_clk) begin
        if (doWrite) begin
            mem[wrPtr] <= inData;
        end
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wrPtr <= '0;
            rdPtr <= '0;
            level <= '0;
        end else begin
            if (doWrite) begin
                wrPtr <= wrPtr + 1'b1;
            end
            if (doRead) begin
                rdPtr <= rdPtr + 1'b1;
            end
            level <= level + (AW+1)'(doWrite) - (AW+1)'(doRead);
        end
    end
endmodule
`default_nettype wire

// >>> logic/uirs_channel.sv
// uirs_channel: decode, infrared codec, loopback and sleep of a channel.
// assumes an async 8-bit host bus; oscillator gating is modelled by an
// osc enable output and a settle counter.
// How it works
// - ir transmit sends high pulse 3/16 bit wide per zero bit
// - ir codec only enabled while modem_control bit 6 is one
// - ir mode: tx idles low, rx treated idle low
// - ir decoder returns one for each sensed light pulse
// - feature_control bit 2 inverts ir receive input first
// - sleep needs no irq, sleep enable, no modem deltas, rx high
// - asleep, oscillator halts and osc output pin stops
// - wake on rx start edge, tx write, or modem input change
// - falls back to sleep once all interrupts are cleared
// - sleep recurs until interrupt_enable bit 4 cleared
// - modem_control bit 4 selects internal loopback
// - loopback feeds transmit shift out into receive input
// - loopback: tx pin mark, rts/dtr off, modem inputs ignored
// - offset 0, divisor access clear: rx/tx holding register
// - divisor access set, not key: offsets 0/1 divisor bytes
// - zero divisor: offsets 0/1 read revision and ident codes
// - key value maps every offset except 3 to enhanced bank
// - offset 7: scratch or level count / mode select by fctr6
// - offset 2 reads interrupt status, writes fifo control
// - line_control at offset 3 reachable from every bank
// - fifo status read whenever fifo_status_select_n is low
`timescale 1ns/1ns
`default_nettype none
module uirs_channel import uirs_pkg::*; #(
    parameter logic [7:0] REVISION = 8'h01, // arbitrary value
    parameter logic [7:0] IDENT = 8'h5A, // arbitrary value
    parameter int SETTLE_CYC = WAKE_SETTLE_CYC,
    parameter int FIFO_WORDS = FIFO_DEPTH
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic chan_a_select_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic fifo_status_select_n,
    input wire logic [2:0] addr,
    input wire logic [7:0] dataIn,
    output logic [7:0] dataOut,
    output logic dataOutEnable,
    input wire logic rxPin,
    output logic txPin,
    input wire logic ctsPin_n,
    input wire logic dsrPin_n,
    input wire logic carrier_detect_n,
    input wire logic ring_indicate_n,
    output logic rtsPin_n,
    output logic dtrPin_n,
    input wire logic othersSleepReady,
    output logic sleepReady,
    output logic oscEnable,
    output logic asleep
);
    // ********************************************************
    // pin synchronisers
    // ********************************************************
    logic [7:0] syncA;
    logic [7:0] syncB;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            syncA <= 8'hFF;
            syncB <= 8'hFF;
        end else begin
            syncA <= {chan_a_select_n, read_strobe_n, write_strobe_n,
                      fifo_status_select_n, ctsPin_n, dsrPin_n,
                      carrier_detect_n, ring_indicate_n};
            syncB <= syncA;
        end
    end
    logic rxSync1;
    logic rxSync2;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rxSync1 <= 1'b1;
            rxSync2 <= 1'b1;
        end else begin
            rxSync1 <= rxPin;
            rxSync2 <= rxSync1;
        end
    end
    logic [10:0] hostA;
    logic [10:0] hostB;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            hostA <= 11'h000;
            hostB <= 11'h000;
        end else begin
            hostA <= {addr, dataIn}; // held steady across the strobe
            hostB <= hostA;
        end
    end
    logic [7:0] busIn;
    logic [2:0] addrS;
    assign {addrS, busIn} = hostB;
    logic selN;
    logic rdN;
    logic wrN;
    logic fsN;
    logic [3:0] modemPins;
    assign {selN, rdN, wrN, fsN} = syncB[7:4];
    assign modemPins = syncB[3:0];
    // ********************************************************
    // strobe edges
    // ********************************************************
    logic rdPrev;
    logic wrPrev;
    logic rdPulse;
    logic wrPulse;
    logic wrFall;
    logic running;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdPrev <= 1'b1;
            wrPrev <= 1'b1;
        end else begin
            rdPrev <= rdN | selN;
            wrPrev <= wrN | selN;
        end
    end
    // act on the falling edge only; logic idles until clock settles
    assign rdPulse = rdPrev && !(rdN | selN) && running;
    assign wrFall = wrPrev && !(wrN | selN);
    assign wrPulse = wrFall && running;
    // ********************************************************
    // registers
    // ********************************************************
    logic [7:0] interrupt_enable;
    logic [7:0] line_control;
    logic [7:0] modem_control;
    logic [7:0] fifo_control;
    logic [7:0] scratch_pad;
    logic [7:0] divisor_low;
    logic [7:0] divisor_high;
    logic [7:0] feature_control;
    logic [7:0] enhanced_function;
    logic [7:0] fifo_trigger_level;
    logic [7:0] enhanced_mode_select;
    logic [7:0] flowChar [4];
    logic enhBank;
    logic divBank;
    assign enhBank = (line_control == ENH_KEY);
    assign divBank = line_control[DIV_ACCESS_POS] && !enhBank;
    logic irOn;
    logic loopOn;
    assign irOn = modem_control[IR_ENABLE_POS];
    assign loopOn = modem_control[LOOPBACK_POS];
    // host writes, decoded by bank then offset
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            interrupt_enable <= ZERO_RESET;
            line_control <= LCTL_RESET;
            modem_control <= ZERO_RESET;
            fifo_control <= ZERO_RESET;
            scratch_pad <= ZERO_RESET;
            divisor_low <= ZERO_RESET;
            divisor_high <= ZERO_RESET;
            feature_control <= ZERO_RESET;
            enhanced_function <= ZERO_RESET;
            fifo_trigger_level <= ZERO_RESET;
            enhanced_mode_select <= ZERO_RESET;
            flowChar <= '{default: ZERO_RESET};
        end else if (wrPulse) begin
            if (addrS == OFS_LCTL) begin
                line_control <= busIn;
            end else if (enhBank) begin
                case (addrS)
                    OFS_DATA: fifo_trigger_level <= busIn;
                    OFS_IEN: feature_control <= busIn;
                    OFS_ISTAT: enhanced_function <= busIn;
                    default: flowChar[addrS[1:0]] <= busIn;
                endcase
            end else if (divBank && addrS == OFS_DATA) begin
                divisor_low <= busIn;
            end else if (divBank && addrS == OFS_IEN) begin
                divisor_high <= busIn;
            end else begin
                case (addrS)
                    OFS_IEN: interrupt_enable <= busIn;
                    OFS_ISTAT: fifo_control <= busIn;
                    OFS_MCTL: modem_control <= busIn;
                    OFS_SCRATCH: begin
                        if (feature_control[LEVEL_SEL_POS]) begin
                            enhanced_mode_select <= busIn;
                        end else begin
                            scratch_pad <= busIn;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end
    logic txWrite;
    assign txWrite = wrFall && addrS == OFS_DATA && !enhBank // kept asleep
                     && !line_control[DIV_ACCESS_POS];
    // ********************************************************
    // data path: tx fifo and simple shifter
    // ********************************************************
    logic txOutValid;
    logic txOutReady;
    logic [7:0] txOutData;
    logic [5:0] txLevel;
    logic [3:0] baudCnt;
    logic [3:0] bitIdx;
    logic [9:0] shiftReg;
    logic shifting;
    logic serialTx;
    logic [7:0] rxHold;
    logic rxReady;
    uirs_fifo #(.WIDTH(8), .DEPTH(FIFO_WORDS)) txFifo (
        .ref_clk(ref_clk),
        .rst(rst),
        .inValid(txWrite),
        .inReady(),
        .inData(busIn),
        .outValid(txOutValid),
        .outReady(txOutReady),
        .outData(txOutData),
        .level(txLevel)
    );
    // shifter stalls the fifo while busy, so it really fills
    assign txOutReady = !shifting && running;
    assign serialTx = shifting ? shiftReg[0] : 1'b1;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            shifting <= 1'b0;
            shiftReg <= 10'h3FF;
            baudCnt <= 4'h0;
            bitIdx <= 4'h0;
        end else if (txOutValid && txOutReady) begin
            shifting <= 1'b1;
            shiftReg <= {1'b1, txOutData, 1'b0};
            baudCnt <= 4'h0;
            bitIdx <= 4'h0;
        end else if (shifting) begin
            baudCnt <= baudCnt + 4'h1; // one bit = 16 clocks here
            if (baudCnt == 4'(OVERSAMPLE - 1)) begin
                shiftReg <= {1'b1, shiftReg[9:1]};
                bitIdx <= bitIdx + 4'h1;
                if (bitIdx == 4'h9) begin
                    shifting <= 1'b0;
                end
            end
        end
    end
    // ********************************************************
    // infrared codec and loopback steering
    // ********************************************************
    logic irTx;
    assign irTx = shifting && !serialTx
                  && baudCnt < 4'(IR_PULSE_SIXTEENTHS);
    logic irRxBit;
    // light pulse (high) reads as a one; dark idle low reads as zero
    assign irRxBit = rxSync2 ^ feature_control[RX_INVERT_POS];
    logic rxStream;
    assign rxStream = loopOn ? serialTx : (irOn ? irRxBit : rxSync2);
    // tiny receive: in loopback only, capture the looped serial bit stream into a byte
    logic [7:0] rxShift;
    logic rxPrevBit;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rxShift <= ZERO_RESET;
            rxHold <= ZERO_RESET;
            rxReady <= 1'b0;
            rxPrevBit <= 1'b1;
        end else begin
            rxPrevBit <= rxStream;
            if (loopOn && shifting && baudCnt == 4'(OVERSAMPLE / 2)
                && bitIdx > 4'h0 && bitIdx < 4'h9) begin
                rxShift <= {rxStream, rxShift[7:1]};
            end
            if (loopOn && shifting && bitIdx == 4'h9
                && baudCnt == 4'(OVERSAMPLE / 2)) begin
                rxHold <= rxShift;
                rxReady <= 1'b1;
            end else if (rdPulse && addrS == OFS_DATA && !enhBank
                         && !line_control[DIV_ACCESS_POS]) begin
                rxReady <= 1'b0;
            end
        end
    end
    // ********************************************************
    // modem status with deltas
    // ********************************************************
    logic [3:0] modemNow;
    logic [3:0] modemPrev;
    logic [3:0] modemDelta;
    // loopback: outputs wrap to inputs, pins ignored
    assign modemNow = loopOn
        ? {modem_control[3], modem_control[2],
           modem_control[0], modem_control[1]}
        : ~{modemPins[1], modemPins[0], modemPins[2], modemPins[3]};
    logic msRead;
    assign msRead = rdPulse && addrS == OFS_MSTAT && !enhBank
                    && !line_control[DIV_ACCESS_POS];
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            modemPrev <= 4'h0;
            modemDelta <= 4'h0;
        end else begin
            modemPrev <= modemNow;
            // a change in the read cycle still sets the delta
            modemDelta <= (msRead ? 4'h0 : modemDelta)
                          | (modemNow ^ modemPrev);
        end
    end
    // ********************************************************
    // interrupt status and sleep control
    // ********************************************************
    logic [7:0] intStatus;
    logic intPending;
    assign intPending = (rxReady && interrupt_enable[0])
                        || (modemDelta != 4'h0 && interrupt_enable[3]);
    assign intStatus = intPending ? 8'h04 : ISTAT_IDLE;
    logic next_sleepReady;
    assign next_sleepReady = intStatus[NO_INT_POS]
        && interrupt_enable[SLEEP_EN_POS]
        && modemDelta == 4'h0 && rxSync2 && txLevel == '0
        && !shifting;
    logic wakeEvent;
    assign wakeEvent = txWrite || (rxPrevBit && !rxSync2 && !loopOn)
                       || (modemNow != modemPrev);
    typedef enum {S_RUN, S_SLEEP, S_SETTLE} uirs_state_type;
    uirs_state_type state;
    logic [$clog2(SETTLE_CYC+1)-1:0] settleCnt;
    assign running = (state == S_RUN);
    // sleep falls in whenever conditions hold again
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state <= S_RUN;
            settleCnt <= '0;
        end else begin
            case (state)
                S_RUN: begin
                    if (next_sleepReady && othersSleepReady) begin
                        state <= S_SLEEP;
                    end
                end
                S_SLEEP: begin
                    if (wakeEvent || !interrupt_enable[SLEEP_EN_POS]) begin
                        state <= S_SETTLE;
                        settleCnt <= '0;
                    end
                end
                S_SETTLE: begin
                    settleCnt <= settleCnt + 1'b1;
                    if (settleCnt == ($bits(settleCnt))'(SETTLE_CYC - 1)) begin
                        state <= S_RUN;
                    end
                end
                default: state <= S_RUN;
            endcase
        end
    end
    // ********************************************************
    // read mux
    // ********************************************************
    logic [7:0] lineStatus;
    logic [7:0] readMux;
    logic divZero;
    assign lineStatus = {1'b0, !shifting && txLevel == '0,
                         txLevel == '0, 4'h0, rxReady};
    assign divZero = divisor_low == 8'h00 && divisor_high == 8'h00;
    always_comb begin
        readMux = ZERO_RESET;
        if (!fsN) begin
            readMux = {7'h0, !txOutValid};
        end else if (addrS == OFS_LCTL) begin
            readMux = line_control;
        end else if (enhBank) begin
            case (addrS)
                OFS_DATA: readMux = {2'h0, txLevel};
                OFS_IEN: readMux = feature_control;
                OFS_ISTAT: readMux = enhanced_function;
                default: readMux = flowChar[addrS[1:0]];
            endcase
        end else if (divBank && addrS == OFS_DATA) begin
            readMux = divZero ? REVISION : divisor_low;
        end else if (divBank && addrS == OFS_IEN) begin
            readMux = divZero ? IDENT : divisor_high;
        end else begin
            case (addrS)
                OFS_DATA: readMux = rxHold;
                OFS_IEN: readMux = interrupt_enable;
                OFS_ISTAT: readMux = intStatus;
                OFS_MCTL: readMux = modem_control;
                OFS_LSTAT: readMux = lineStatus;
                OFS_MSTAT: readMux = {modemNow, modemDelta};
                OFS_SCRATCH: readMux = feature_control[LEVEL_SEL_POS]
                    ? {2'h0, txLevel} : scratch_pad;
                default: readMux = ZERO_RESET;
            endcase
        end
    end
    // ********************************************************
    // registered outputs
    // ********************************************************
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dataOut <= ZERO_RESET;
            dataOutEnable <= 1'b0;
            txPin <= 1'b1;
            rtsPin_n <= 1'b1;
            dtrPin_n <= 1'b1;
            sleepReady <= 1'b0;
            oscEnable <= 1'b1;
            asleep <= 1'b0;
        end else begin
            dataOut <= readMux;
            dataOutEnable <= !(rdN | selN) && running;
            txPin <= loopOn ? 1'b1 : (irOn ? irTx : serialTx);
            rtsPin_n <= loopOn ? 1'b1 : !modem_control[1];
            dtrPin_n <= loopOn ? 1'b1 : !modem_control[0];
            sleepReady <= next_sleepReady;
            oscEnable <= (state != S_SLEEP);
            asleep <= (state == S_SLEEP);
        end
    end
endmodule
`default_nettype wire

// >>> sim/uirs_assertions.sv
// uirs_assertions: port-level checks bound into uirs_channel.
// assumes the channel's port names; wake seen within a few syncs.
`timescale 1ns/1ns
`default_nettype none
module uirs_assertions import uirs_pkg::*; (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic chan_a_select_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic [2:0] addr,
    input wire logic rxPin,
    input wire logic ctsPin_n,
    input wire logic ring_indicate_n,
    input wire logic dataOutEnable,
    input wire logic othersSleepReady,
    input wire logic sleepReady,
    input wire logic oscEnable,
    input wire logic asleep
);
    // one domain: shared clock and reset for every property
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    osc_stop_a: assert property (asleep |-> !oscEnable)
        else $error("oscillator running while asleep");
    sleep_gate_a: assert property (!(sleepReady && othersSleepReady)
        && !asleep |=> !asleep) else $error("sleep without conditions");
    wake_cts_a: assert property (asleep && $changed(ctsPin_n)
        |-> ##[1:8] !asleep) else $error("no wake on cts change");
    wake_ring_a: assert property (asleep && $changed(ring_indicate_n)
        |-> ##[1:8] !asleep) else $error("no wake on ring change");
    wake_rx_a: assert property (asleep && $fell(rxPin)
        |-> ##[1:8] !asleep) else $error("no wake on start edge");
    wake_write_a: assert property (asleep && $fell(write_strobe_n)
        && !chan_a_select_n && addr == OFS_DATA |-> ##[1:8] !asleep)
        else $error("no wake on transmit write");
    read_idle_a: assert property (
        read_strobe_n [*5] |-> !dataOutEnable)
        else $error("data bus driven without read");
    sleep_deaf_a: assert property (asleep |-> !dataOutEnable)
        else $error("data bus driven while asleep");
    // main scenarios reached
    cover property ($rose(asleep));
    cover property ($fell(asleep));
    cover property ($rose(dataOutEnable));
endmodule
bind uirs_channel uirs_assertions u_chk (.ref_clk, .rst, .chan_a_select_n,
    .read_strobe_n, .write_strobe_n, .addr, .rxPin, .ctsPin_n,
    .ring_indicate_n, .dataOutEnable, .othersSleepReady, .sleepReady,
    .oscEnable, .asleep);
`default_nettype wire

// >>> sim/uirs_remote.sv
// uirs_remote: far-end serial line and modem of one channel.
// assumes the bench raises its requests after a falling edge.
`timescale 1ns/1ns
`default_nettype none
module uirs_remote (
    input wire logic ref_clk,
    input wire logic ctsReq,
    input wire logic riReq,
    input wire logic rxBreak,
    output logic rxPin = 1'b1,
    output logic ctsPin_n = 1'b1,
    output logic ring_indicate_n = 1'b1,
    output logic dsrPin_n,
    output logic carrier_detect_n
);
    // line rests at mark so sleep and loopback exit stay clean
    always @(negedge ref_clk) begin
        rxPin <= !rxBreak;
        ctsPin_n <= !ctsReq;
        ring_indicate_n <= !riReq;
    end
    // parked modem inputs: steady, so they never block sleep
    assign dsrPin_n = 1'b1;
    assign carrier_detect_n = 1'b1;
endmodule
`default_nettype wire

// >>> sim/uirs_channel_tb_top.sv
// uirs_channel_tb_top: self-checking bench for one uart channel.
// assumes uirs_remote at the line side; settle shortened to 4.
`timescale 1ns/1ns
`default_nettype none
module uirs_channel_tb_top import uirs_pkg::*; ;
    localparam logic [7:0] REV = 8'h01; // arbitrary value
    localparam logic [7:0] IDN = 8'h5A; // arbitrary value
    logic ref_clk = 1'b0, rst = 1'b1, chan_a_select_n = 1'b1;
    logic read_strobe_n = 1'b1, write_strobe_n = 1'b1, txPrev = 1'b0;
    logic fifo_status_select_n = 1'b1, othersSleepReady = 1'b0;
    logic ctsReq = 1'b0, riReq = 1'b0, rxBreak = 1'b0, count = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] dataIn = 8'h00, dataOut, rd;
    logic [31:0] seed = 32'h4DC4;
    logic dataOutEnable, rxPin, txPin, ctsPin_n, dsrPin_n, rtsPin_n, dtrPin_n;
    logic carrier_detect_n, ring_indicate_n, sleepReady, oscEnable, asleep;
    int miscompares = 0, checked = 0, highs = 0, pulses = 0, n;
    always #50 ref_clk = ~ref_clk;
    uirs_channel #(.REVISION(REV), .IDENT(IDN), .SETTLE_CYC(4)) i_dut (
        .ref_clk, .rst, .chan_a_select_n, .read_strobe_n, .write_strobe_n,
        .fifo_status_select_n, .addr, .dataIn, .dataOut, .dataOutEnable,
        .rxPin, .txPin, .ctsPin_n, .dsrPin_n, .carrier_detect_n,
        .ring_indicate_n, .rtsPin_n, .dtrPin_n, .othersSleepReady,
        .sleepReady, .oscEnable, .asleep);
    uirs_remote i_far (.ref_clk, .ctsReq, .riReq, .rxBreak, .rxPin,
        .ctsPin_n, .dsrPin_n, .carrier_detect_n, .ring_indicate_n);
    // ir pulse meter: counts high cycles and rising edges on tx
    always @(posedge ref_clk) begin
        txPrev <= txPin;
        if (count && txPin)
            highs++;
        if (count && txPin && !txPrev)
            pulses++;
    end
    // ********************************
    // helpers
    // ********************************
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic summarize();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // strobes held six cycles so the 2-FF sync always catches them
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        {addr, dataIn, chan_a_select_n, write_strobe_n} = {a, d, 2'b00};
        repeat (6) @(negedge ref_clk);
        {chan_a_select_n, write_strobe_n} = 2'b11;
        repeat (4) @(negedge ref_clk);
    endtask
    task automatic rdr(input logic [2:0] a, input logic fsn);
        @(negedge ref_clk);
        {addr, fifo_status_select_n} = {a, fsn};
        {chan_a_select_n, read_strobe_n} = 2'b00;
        repeat (6) @(negedge ref_clk);
        rd = dataOut;
        {chan_a_select_n, read_strobe_n, fifo_status_select_n} = 3'b111;
        repeat (4) @(negedge ref_clk);
    endtask
    task automatic waitSleep(input logic v);
        n = 0;
        while (asleep !== v && n < 300) begin
            @(negedge ref_clk);
            n++;
        end
        chk("asleep", {7'h0, asleep}, {7'h0, v});
        if (n == 300)
            summarize();
        else
            repeat (8) @(negedge ref_clk);
    endtask
    initial begin
        #(100000 * 100);
        miscompares++;
        summarize();
    end
    initial begin
        repeat (20) @(negedge ref_clk);
        chk("reset pins", {4'h0, txPin, rtsPin_n, dtrPin_n, oscEnable}, 8'h0F);
        rst = 1'b0;
        seed = xs(seed);
        wr(OFS_SCRATCH, seed[7:0]);
        rdr(OFS_SCRATCH, 1'b1);
        chk("scratch", rd, seed[7:0]);
        rdr(OFS_ISTAT, 1'b1);
        chk("istat", rd, ISTAT_IDLE);
        wr(OFS_LCTL, 8'h80);
        rdr(OFS_DATA, 1'b1);
        chk("revision", rd, REV);
        rdr(OFS_IEN, 1'b1);
        chk("ident", rd, IDN);
        wr(OFS_IEN, seed[15:8] | 8'h01);
        rdr(OFS_IEN, 1'b1);
        chk("div high", rd, seed[15:8] | 8'h01);
        wr(OFS_LCTL, ENH_KEY);
        wr(OFS_IEN, 8'h04);
        rdr(OFS_IEN, 1'b1);
        chk("feature", rd, 8'h04);
        rdr(OFS_LCTL, 1'b1);
        chk("line ctl", rd, ENH_KEY);
        wr(OFS_LCTL, LCTL_RESET);
        wr(OFS_MCTL, 8'h13);
        ctsReq = 1'b1;
        wr(OFS_DATA, seed[23:16]);
        repeat (200) begin
            @(negedge ref_clk);
            chk("loop pins", {5'h0, txPin, rtsPin_n, dtrPin_n}, 8'h07);
        end
        rdr(OFS_LSTAT, 1'b1);
        chk("rx ready", {7'h0, rd[LSR_DR_POS]}, 8'h01);
        rdr(OFS_DATA, 1'b1);
        chk("loop data", rd, seed[23:16]);
        ctsReq = 1'b0;
        wr(OFS_MCTL, 8'h40);
        chk("ir idle", {7'h0, txPin}, 8'h00);
        count = 1'b1;
        wr(OFS_DATA, 8'h00);
        repeat (200) @(negedge ref_clk);
        count = 1'b0;
        chk("ir high", highs[7:0], 8'h1B);
        chk("ir pulses", pulses[7:0], 8'h09);
        rdr(seed[26:24], 1'b0);
        chk("fifo stat", rd, 8'h01);
        wr(OFS_MCTL, 8'h00);
        wr(OFS_IEN, 8'h10);
        rdr(OFS_MSTAT, 1'b1);
        repeat (50) @(negedge ref_clk);
        chk("no sleep", {7'h0, asleep}, 8'h00);
        othersSleepReady = 1'b1;
        waitSleep(1'b1);
        chk("osc", {7'h0, oscEnable}, 8'h00);
        ctsReq = 1'b1;
        waitSleep(1'b0);
        rdr(OFS_MSTAT, 1'b1);
        waitSleep(1'b1);
        rxBreak = 1'b1;
        waitSleep(1'b0);
        rxBreak = 1'b0;
        waitSleep(1'b1);
        wr(OFS_DATA, 8'h00);
        waitSleep(1'b0);
        waitSleep(1'b1);
        riReq = 1'b1;
        waitSleep(1'b0);
        wr(OFS_IEN, 8'h00);
        rdr(OFS_MSTAT, 1'b1);
        repeat (100) @(negedge ref_clk);
        chk("awake", {7'h0, asleep}, 8'h00);
        summarize();
    end
endmodule
`default_nettype wire
